/* design/cip_pkg.sv */
// Package: register map, field positions, reset values and priority codes
package cip_pkg;
   // Register byte offsets on APB
   localparam logic [11:0] FLAG_OFFS   = 12'h000;
   localparam logic [11:0] ENABLE_OFFS = 12'h004;
   localparam logic [11:0] STATUS_OFFS = 12'h008;
   localparam logic [11:0] CODE_OFFS   = 12'h00C;
   localparam logic [11:0] COUNT_OFFS  = 12'h010;
   localparam logic [11:0] CTRL_OFFS   = 12'h014;

   // Flag and enable bit positions
   localparam int RX0_BIT = 0;
   localparam int RX1_BIT = 1;
   localparam int TX0_BIT = 2;
   localparam int TX1_BIT = 3;
   localparam int TX2_BIT = 4;
   localparam int ERR_BIT = 5;
   localparam int WAK_BIT = 6;
   localparam int MER_BIT = 7;
   localparam int NUM_SRC = 8;

   // Status bit positions
   localparam int OVF0_BIT = 0;
   localparam int OVF1_BIT = 1;
   localparam int RXW_BIT  = 2;
   localparam int TXW_BIT  = 3;
   localparam int RXP_BIT  = 4;
   localparam int TXP_BIT  = 5;
   localparam int BOFF_BIT = 6;
   localparam int EWRN_BIT = 7;

   // Reset values
   localparam logic [7:0] FLAG_RST   = 8'h00;
   localparam logic [7:0] ENABLE_RST = 8'h00;
   localparam logic [7:0] TX_FLAG_RST = 8'h00;

   // Error limits
   localparam logic [8:0] WARN_LIMIT    = 9'h060;
   localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
   localparam logic [8:0] BUSOFF_LIMIT  = 9'h0FF;

   // Priority codes
   localparam logic [2:0] CODE_NONE = 3'h0;
   localparam logic [2:0] CODE_ERR  = 3'h1;
   localparam logic [2:0] CODE_TX2  = 3'h2;
   localparam logic [2:0] CODE_TX1  = 3'h3;
   localparam logic [2:0] CODE_TX0  = 3'h4;
   localparam logic [2:0] CODE_RX1  = 3'h5;
   localparam logic [2:0] CODE_RX0  = 3'h6;
   localparam logic [2:0] CODE_WAK  = 3'h7;

   // Error modes
   typedef enum logic [1:0]
   {
      CIP_ACTIVE  = 2'b00,
      CIP_PASSIVE = 2'b01,
      CIP_BUSOFF  = 2'b11
   } cip_mode_t;
endpackage

/* design/cip_prioritizer.sv */
// CAN interrupt flags, enables, error status and priority code with APB access
//
// Behaviour
// - Receive flag set on error-free store at end of frame.
// - Code: err 1, tx0 4, tx1 3, tx2 2, rx0 6, rx1 5, wake 7, none 0.
// - Each code term is flag AND enable.
// - Any message error sets message-error flag; interrupt only when enabled.
// - Bus activity in sleep with wake enabled sets wake flag and wakes.
// - Error flag set on overflow or transmitter/receiver error state change.
// - Overflow status bit set when matched receive buffer is full.
// - Receiver warning when receive error count reaches 96.
// - Transmitter warning when transmit error count reaches 96.
// - Receive count above 127 gives error-passive and receiver-passive bit.
// - Transmit count above 127 gives error-passive and transmitter-passive bit.
// - Transmit count above 255 gives bus-off state and bus-off bit.
// - Interrupt pending while any associated flag is set.
// - Software clear ignored while the causing condition is present.
// - Code moves to next pending enabled source after a clear.
// - Transmit flag set when buffer empties; cleared by writing 0.
// - Single error flag; cause readable from communication status register.
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/100ps
module cip_prioritizer
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [1:0]  rx_done,
   input  wire logic [1:0]  rx_full_drop,
   input  wire logic [2:0]  tx_empty,
   input  wire logic        msg_error,
   input  wire logic        bus_activity,
   input  wire logic [7:0]  rx_err_count,
   input  wire logic [8:0]  tx_err_count,
   output logic             irq,
   output logic [2:0]       irq_priority_code,
   output logic             sleep_exit
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0]  flag_q, flag_d;
   logic [7:0]  enable_q, enable_d;
   logic [1:0]  ovf_q, ovf_d;
   logic        sleep_q, sleep_d;
   logic [5:0]  err_st_q;
   logic [5:0]  err_st;
   logic [31:0] prdata_d;
   logic        pready_d, pslverr_d, irq_d, sleep_exit_d;
   logic [2:0]  code_d;
   logic [7:0]  term;
   logic [7:0]  set_ev;
   logic [7:0]  cond;
   logic        wr_acc, rd_acc, ack_q;
   cip_pkg::cip_mode_t mode;

   ////////////////////////////////////////////////////////////////////////
   // Error condition decode
   always_comb
   begin
      err_st[cip_pkg::RXW_BIT - 2]  = {1'b0, rx_err_count} >= cip_pkg::WARN_LIMIT;
      err_st[cip_pkg::TXW_BIT - 2]  = tx_err_count >= cip_pkg::WARN_LIMIT;
      err_st[cip_pkg::RXP_BIT - 2]  = {1'b0, rx_err_count} > cip_pkg::PASSIVE_LIMIT;
      err_st[cip_pkg::TXP_BIT - 2]  = tx_err_count > cip_pkg::PASSIVE_LIMIT;
      err_st[cip_pkg::BOFF_BIT - 2] = tx_err_count > cip_pkg::BUSOFF_LIMIT;
      err_st[cip_pkg::EWRN_BIT - 2] = err_st[0] | err_st[1];
      if (err_st[cip_pkg::BOFF_BIT - 2])
         mode = cip_pkg::CIP_BUSOFF;
      else if (err_st[2] | err_st[3])
         mode = cip_pkg::CIP_PASSIVE;
      else
         mode = cip_pkg::CIP_ACTIVE;
   end

   ////////////////////////////////////////////////////////////////////////
   // Flag set events and live conditions
   always_comb
   begin
      set_ev = '0;
      set_ev[cip_pkg::RX0_BIT] = rx_done[0];
      set_ev[cip_pkg::RX1_BIT] = rx_done[1];
      set_ev[cip_pkg::TX0_BIT] = tx_empty[0];
      set_ev[cip_pkg::TX1_BIT] = tx_empty[1];
      set_ev[cip_pkg::TX2_BIT] = tx_empty[2];
      set_ev[cip_pkg::ERR_BIT] = (|rx_full_drop) | (err_st != err_st_q);
      set_ev[cip_pkg::WAK_BIT] = sleep_q & enable_q[cip_pkg::WAK_BIT] & bus_activity;
      set_ev[cip_pkg::MER_BIT] = msg_error;
      cond = set_ev;
      cond[cip_pkg::TX0_BIT] = cond[cip_pkg::TX0_BIT];
   end

   // Writes land at the edge at which the master sees pready
   assign wr_acc = psel & penable & pwrite & pready;
   assign rd_acc = psel & penable & ~pwrite & ~ack_q;

   ////////////////////////////////////////////////////////////////////////
   // Register next state
   always_comb
   begin
      flag_d   = flag_q;
      enable_d = enable_q;
      ovf_d    = ovf_q;
      sleep_d  = sleep_q;
      if (wr_acc && pstrb[0])
      begin
         unique case (paddr)
            cip_pkg::FLAG_OFFS:   flag_d = flag_q & pwdata[7:0];
            cip_pkg::ENABLE_OFFS: enable_d = pwdata[7:0];
            cip_pkg::STATUS_OFFS: ovf_d = ovf_q & pwdata[1:0];
            cip_pkg::CTRL_OFFS:   sleep_d = pwdata[0];
            default:              flag_d = flag_q;
         endcase
      end
      flag_d = flag_d | set_ev | (flag_q & cond);
      ovf_d  = ovf_d | rx_full_drop;
      if (set_ev[cip_pkg::WAK_BIT])
         sleep_d = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Priority code and request
   always_comb
   begin
      term  = flag_d & enable_d;
      irq_d = |term;
      if (term[cip_pkg::ERR_BIT])
         code_d = cip_pkg::CODE_ERR;
      else if (term[cip_pkg::TX0_BIT])
         code_d = cip_pkg::CODE_TX0;
      else if (term[cip_pkg::TX1_BIT])
         code_d = cip_pkg::CODE_TX1;
      else if (term[cip_pkg::TX2_BIT])
         code_d = cip_pkg::CODE_TX2;
      else if (term[cip_pkg::RX0_BIT])
         code_d = cip_pkg::CODE_RX0;
      else if (term[cip_pkg::RX1_BIT])
         code_d = cip_pkg::CODE_RX1;
      else if (term[cip_pkg::WAK_BIT])
         code_d = cip_pkg::CODE_WAK;
      else
         code_d = cip_pkg::CODE_NONE;
      sleep_exit_d = set_ev[cip_pkg::WAK_BIT];
   end

   ////////////////////////////////////////////////////////////////////////
   // APB read data and answer
   always_comb
   begin
      prdata_d  = 32'h0000_0000;
      pready_d  = psel & penable & ~ack_q;
      pslverr_d = 1'b0;
      unique case (paddr)
         cip_pkg::FLAG_OFFS:   prdata_d[7:0] = flag_q;
         cip_pkg::ENABLE_OFFS: prdata_d[7:0] = enable_q;
         cip_pkg::STATUS_OFFS: prdata_d[7:0] = {err_st, ovf_q};
         cip_pkg::CODE_OFFS:   prdata_d[4:0] = {mode, irq_priority_code};
         cip_pkg::COUNT_OFFS:  prdata_d[16:0] = {tx_err_count, rx_err_count};
         cip_pkg::CTRL_OFFS:   prdata_d[0] = sleep_q;
         default:              pslverr_d = psel & penable;
      endcase
      if (!rd_acc)
         prdata_d = 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag_q            <= cip_pkg::FLAG_RST;
         enable_q          <= cip_pkg::ENABLE_RST;
         ovf_q             <= 2'b00;
         sleep_q           <= 1'b0;
         err_st_q          <= 6'h00;
         ack_q             <= 1'b0;
         prdata            <= 32'h0000_0000;
         pready            <= 1'b0;
         pslverr           <= 1'b0;
         irq               <= 1'b0;
         irq_priority_code <= cip_pkg::CODE_NONE;
         sleep_exit        <= 1'b0;
      end
      else if (clk_en)
      begin
         flag_q            <= flag_d;
         enable_q          <= enable_d;
         ovf_q             <= ovf_d;
         sleep_q           <= sleep_d;
         err_st_q          <= err_st;
         ack_q             <= pready_d;
         prdata            <= prdata_d;
         pready            <= pready_d;
         pslverr           <= pslverr_d & ~ack_q;
         irq               <= irq_d;
         irq_priority_code <= code_d;
         sleep_exit        <= sleep_exit_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_rx_set;
      @(posedge pclk) disable iff (!presetn)
      clk_en && rx_done[0] |=> flag_q[cip_pkg::RX0_BIT];
   endproperty
   a_rx_set: assert property (p_rx_set) else $error("rx0 flag not set");

   property p_rx_hold;
      @(posedge pclk) disable iff (!presetn)
      flag_q[cip_pkg::RX0_BIT] && !(wr_acc && paddr == cip_pkg::FLAG_OFFS)
      |=> flag_q[cip_pkg::RX0_BIT];
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("rx0 flag lost");

   property p_code_err;
      @(posedge pclk) disable iff (!presetn)
      clk_en && flag_d[cip_pkg::ERR_BIT] && enable_d[cip_pkg::ERR_BIT]
      |=> irq_priority_code == cip_pkg::CODE_ERR;
   endproperty
   a_code_err: assert property (p_code_err) else $error("error code wrong");

   property p_code_masked;
      @(posedge pclk) disable iff (!presetn)
      clk_en && enable_d == 8'h00 |=> irq_priority_code == cip_pkg::CODE_NONE && !irq;
   endproperty
   a_code_masked: assert property (p_code_masked) else $error("masked source shown");

   property p_msg_err;
      @(posedge pclk) disable iff (!presetn)
      clk_en && msg_error |=> flag_q[cip_pkg::MER_BIT];
   endproperty
   a_msg_err: assert property (p_msg_err) else $error("message error lost");

   property p_wake;
      @(posedge pclk) disable iff (!presetn)
      clk_en && sleep_q && enable_q[cip_pkg::WAK_BIT] && bus_activity
      |=> flag_q[cip_pkg::WAK_BIT] && !sleep_q && sleep_exit;
   endproperty
   a_wake: assert property (p_wake) else $error("wake failed");

   property p_ovf_keep;
      @(posedge pclk) disable iff (!presetn)
      ovf_q[0] && !(wr_acc && paddr == cip_pkg::STATUS_OFFS) |=> ovf_q[0];
   endproperty
   a_ovf_keep: assert property (p_ovf_keep) else $error("overflow bit lost");

   property p_busoff;
      @(posedge pclk) disable iff (!presetn)
      tx_err_count > 9'h0FF |-> mode == cip_pkg::CIP_BUSOFF;
   endproperty
   a_busoff: assert property (p_busoff) else $error("bus-off missed");

   property p_irq;
      @(posedge pclk) disable iff (!presetn)
      clk_en ##1 1'b1 |-> irq == |(flag_q & enable_q);
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");

   property p_tx_set;
      @(posedge pclk) disable iff (!presetn)
      clk_en && tx_empty[2] |=> flag_q[cip_pkg::TX2_BIT];
   endproperty
   a_tx_set: assert property (p_tx_set) else $error("tx2 flag not set");

   property p_err_change;
      @(posedge pclk) disable iff (!presetn)
      clk_en && err_st != err_st_q |=> flag_q[cip_pkg::ERR_BIT];
   endproperty
   a_err_change: assert property (p_err_change) else $error("error flag missed");

   property p_ovf_set;
      @(posedge pclk) disable iff (!presetn)
      clk_en && rx_full_drop[1] |=> ovf_q[1];
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("overflow bit not set");

   property p_ovf0;
      @(posedge pclk) disable iff (!presetn)
      clk_en && rx_full_drop[0] |=> ovf_q[0] && flag_q[cip_pkg::ERR_BIT];
   endproperty
   a_ovf0: assert property (p_ovf0) else $error("overflow cause lost");

   property p_rx_warn;
      @(posedge pclk) disable iff (!presetn)
      err_st[0] == (rx_err_count >= 8'h60);
   endproperty
   a_rx_warn: assert property (p_rx_warn) else $error("receive warning wrong");

   property p_tx_warn;
      @(posedge pclk) disable iff (!presetn)
      err_st[1] == (tx_err_count >= 9'h060);
   endproperty
   a_tx_warn: assert property (p_tx_warn) else $error("transmit warning wrong");

   property p_rx_pass;
      @(posedge pclk) disable iff (!presetn)
      rx_err_count > 8'h7F |-> err_st[2] && mode != cip_pkg::CIP_ACTIVE;
   endproperty
   a_rx_pass: assert property (p_rx_pass) else $error("receive passive missed");

   property p_tx_pass;
      @(posedge pclk) disable iff (!presetn)
      tx_err_count > 9'h07F |-> err_st[3] && mode != cip_pkg::CIP_ACTIVE;
   endproperty
   a_tx_pass: assert property (p_tx_pass) else $error("transmit passive missed");

   property p_set_wins;
      @(posedge pclk) disable iff (!presetn)
      clk_en && wr_acc && pstrb[0] && paddr == cip_pkg::FLAG_OFFS && set_ev[0] |=> flag_q[0];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat set");

   property p_code_tx0;
      @(posedge pclk) disable iff (!presetn)
      clk_en && term[2] && !term[5] |=> irq_priority_code == cip_pkg::CODE_TX0;
   endproperty
   a_code_tx0: assert property (p_code_tx0) else $error("tx0 code wrong");

   property p_code_rx1;
      @(posedge pclk) disable iff (!presetn)
      clk_en && (term & 8'h7F) == 8'h02 |=> irq_priority_code == cip_pkg::CODE_RX1;
   endproperty
   a_code_rx1: assert property (p_code_rx1) else $error("next code wrong");

   property p_wake_quiet;
      @(posedge pclk) disable iff (!presetn)
      clk_en && !sleep_q |=> !sleep_exit;
   endproperty
   a_wake_quiet: assert property (p_wake_quiet) else $error("wake while awake");

   property p_mer_irq;
      @(posedge pclk) disable iff (!presetn)
      clk_en && flag_d[cip_pkg::MER_BIT] && enable_d[cip_pkg::MER_BIT] |=> irq;
   endproperty
   a_mer_irq: assert property (p_mer_irq) else $error("message error irq missed");

   property p_freeze;
      @(posedge pclk) disable iff (!presetn)
      !clk_en |=> $stable(flag_q) && $stable(enable_q) && $stable(ovf_q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule

/* testbench/can_interrupt_prioritizer_bench.sv */
// Bench: APB accesses and CAN event scenarios for the interrupt prioritizer
`timescale 1ns/100ps
module can_interrupt_prioritizer_bench;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        clk_en = 1'b1;
   logic [3:0]  pstrb = 4'hF;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [1:0]  rx_done;
   logic [1:0]  rx_full_drop;
   logic [2:0]  tx_empty;
   logic        msg_error;
   logic        bus_activity;
   logic [7:0]  rx_err_count;
   logic [8:0]  tx_err_count;
   logic        irq;
   logic [2:0]  irq_priority_code;
   logic        sleep_exit;
   logic        slv_err;
   logic [31:0] rd;
   int          err_total = 0;
   int          num_checks = 0;
   int          wake_cnt = 0;
   logic [8:0]  ev_tab [5] = '{9'h100, 9'h080, 9'h010, 9'h008, 9'h004};
   logic [31:0] code_tab [5] = '{32'h5, 32'h6, 32'h2, 32'h3, 32'h4};
   int          bit_tab [5] = '{1, 0, 4, 3, 2};
   logic [7:0]  rc_tab [5] = '{8'h60, 8'h60, 8'h80, 8'h00, 8'h00};
   logic [8:0]  tc_tab [5] = '{9'h000, 9'h060, 9'h060, 9'h100, 9'h000};
   logic [31:0] st_tab [5] = '{32'h84, 32'h8C, 32'h9C, 32'hE8, 32'h00};
   logic [31:0] md_tab [5] = '{32'h01, 32'h01, 32'h09, 32'h19, 32'h01};

   always #4 pclk = ~pclk;

   always @(posedge pclk)
      if (sleep_exit === 1'b1)
         wake_cnt <= wake_cnt + 1;

   cip_prioritizer cip_prioritizer_i
   (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_done(rx_done), .rx_full_drop(rx_full_drop),
      .tx_empty(tx_empty), .msg_error(msg_error), .bus_activity(bus_activity),
      .rx_err_count(rx_err_count), .tx_err_count(tx_err_count), .irq(irq),
      .irq_priority_code(irq_priority_code), .sleep_exit(sleep_exit)
   );

   cip_can_engine cip_can_engine_i
   (
      .pclk(pclk), .rx_done(rx_done), .rx_full_drop(rx_full_drop), .tx_empty(tx_empty),
      .msg_error(msg_error), .bus_activity(bus_activity), .rx_err_count(rx_err_count),
      .tx_err_count(tx_err_count)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("Checks %0d, errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      slv_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      repeat (2) @(posedge pclk);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #100000;
      err_total++;
      wrap_up();
   end

   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rdc(cip_pkg::FLAG_OFFS, 32'h0000_0000);
      rdc(cip_pkg::ENABLE_OFFS, 32'h0000_0000);
      // Disabled source kept out of code and request
      cip_can_engine_i.fire(9'h004);
      rdc(cip_pkg::FLAG_OFFS, 32'h0000_0004);
      rdc(cip_pkg::CODE_OFFS, 32'h0000_0000);
      chk({31'h0, irq}, 32'h0);
      wr(cip_pkg::ENABLE_OFFS, 32'h0000_007F);
      rdc(cip_pkg::CODE_OFFS, 32'h0000_0004);
      chk({31'h0, irq}, 32'h1);
      wr(cip_pkg::FLAG_OFFS, 32'hFFFF_FFFB);
      rdc(cip_pkg::FLAG_OFFS, 32'h0000_0000);
      // Raise sources in rising priority, then clear from the top
      for (int i = 0; i < 5; i++)
      begin
         cip_can_engine_i.fire(ev_tab[i]);
         rdc(cip_pkg::CODE_OFFS, code_tab[i]);
      end
      wr(cip_pkg::FLAG_OFFS, 32'hFFFF_FFFF);
      rdc(cip_pkg::FLAG_OFFS, 32'h0000_001F);
      for (int i = 4; i >= 0; i--)
      begin
         wr(cip_pkg::FLAG_OFFS, ~(32'h1 << bit_tab[i]));
         chk({29'h0, irq_priority_code}, (i > 0) ? code_tab[i-1] : 32'h0);
      end
      chk({31'h0, irq}, 32'h0);
      // Error counter thresholds and error modes
      for (int i = 0; i < 5; i++)
      begin
         cip_can_engine_i.counts(rc_tab[i], tc_tab[i]);
         repeat (2) @(posedge pclk);
         rdc(cip_pkg::STATUS_OFFS, st_tab[i]);
         rdc(cip_pkg::CODE_OFFS, md_tab[i]);
         rdc(cip_pkg::COUNT_OFFS, {15'h0000, tc_tab[i], rc_tab[i]});
      end
      wr(cip_pkg::FLAG_OFFS, 32'hFFFF_FFDF);
      rdc(cip_pkg::CODE_OFFS, 32'h0000_0000);
      // Receive overflow held until software clears it
      cip_can_engine_i.fire(9'h060);
      rdc(cip_pkg::STATUS_OFFS, 32'h0000_0003);
      rdc(cip_pkg::FLAG_OFFS, 32'h0000_0020);
      wr(cip_pkg::STATUS_OFFS, 32'hFFFF_FFFD);
      rdc(cip_pkg::STATUS_OFFS, 32'h0000_0001);
      wr(cip_pkg::STATUS_OFFS, 32'hFFFF_FFFE);
      rdc(cip_pkg::STATUS_OFFS, 32'h0000_0000);
      wr(cip_pkg::FLAG_OFFS, 32'hFFFF_FFDF);
      // Frozen clock enable, then a write with lane 0 off
      clk_en <= 1'b0;
      cip_can_engine_i.fire(9'h004);
      clk_en <= 1'b1;
      rdc(cip_pkg::FLAG_OFFS, 32'h0000_0000);
      pstrb <= 4'hE;
      wr(cip_pkg::ENABLE_OFFS, 32'h0000_0000);
      pstrb <= 4'hF;
      rdc(cip_pkg::ENABLE_OFFS, 32'h0000_007F);
      // Receive event in the cycle of a software clear
      fork
         wr(cip_pkg::FLAG_OFFS, 32'hFFFF_FFFE);
         begin
            repeat (2) @(posedge pclk);
            cip_can_engine_i.fire(9'h080);
         end
      join
      rdc(cip_pkg::FLAG_OFFS, 32'h0000_0001);
      wr(cip_pkg::FLAG_OFFS, 32'hFFFF_FFFE);
      // Message error with and without its enable
      cip_can_engine_i.fire(9'h002);
      rdc(cip_pkg::FLAG_OFFS, 32'h0000_0080);
      chk({31'h0, irq}, 32'h0);
      wr(cip_pkg::ENABLE_OFFS, 32'h0000_00FF);
      chk({31'h0, irq}, 32'h1);
      rdc(cip_pkg::CODE_OFFS, 32'h0000_0000);
      wr(cip_pkg::FLAG_OFFS, 32'hFFFF_FF7F);
      // Bus activity while asleep
      wr(cip_pkg::CTRL_OFFS, 32'h0000_0001);
      rdc(cip_pkg::CTRL_OFFS, 32'h0000_0001);
      cip_can_engine_i.fire(9'h001);
      repeat (2) @(posedge pclk);
      rdc(cip_pkg::FLAG_OFFS, 32'h0000_0040);
      rdc(cip_pkg::CTRL_OFFS, 32'h0000_0000);
      rdc(cip_pkg::CODE_OFFS, 32'h0000_0007);
      chk(32'(wake_cnt), 32'h1);
      wr(cip_pkg::FLAG_OFFS, 32'hFFFF_FFBF);
      rdc(cip_pkg::CODE_OFFS, 32'h0000_0000);
      chk({31'h0, irq}, 32'h0);
      // Reset in mid-run clears the enables
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(cip_pkg::ENABLE_OFFS, 32'h0000_0000);
      // Unmapped address
      rdc(12'h020, 32'h0000_0000);
      chk({31'h0, slv_err}, 32'h1);
      wrap_up();
   end
endmodule

/* testbench/cip_can_engine.sv */
// CAN engine model: frame events and error counter levels toward the prioritizer
`timescale 1ns/100ps
module cip_can_engine
(
   input  wire logic       pclk,
   output logic [1:0]      rx_done,
   output logic [1:0]      rx_full_drop,
   output logic [2:0]      tx_empty,
   output logic            msg_error,
   output logic            bus_activity,
   output logic [7:0]      rx_err_count,
   output logic [8:0]      tx_err_count
);
   logic [8:0] ev_q = 9'h000;

   assign {rx_done, rx_full_drop, tx_empty, msg_error, bus_activity} = ev_q;

   initial
   begin
      rx_err_count = 8'h00;
      tx_err_count = 9'h000;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One-cycle event, raised and dropped just after rising edges
   task automatic fire(input logic [8:0] e);
      @(posedge pclk);
      ev_q <= e;
      @(posedge pclk);
      ev_q <= 9'h000;
   endtask

   // Live counter levels
   task automatic counts(input logic [7:0] r, input logic [8:0] t);
      @(posedge pclk);
      rx_err_count <= r;
      tx_err_count <= t;
   endtask
endmodule
